// ---- rtl/chan_ctrl.sv ----
// Channel run gating, switching cycle, clock select and register slave
// How it works
// - Enable pin low: shutdown, supplies off, all config registers back to reset.
// - Channel runs only with pin high, bias ok, enable bit set, dimming high, level above eight.
// - Channel clock rising edge starts a cycle and turns the switch on.
// - Comparator trip ends the cycle and turns the switch off.
// - Bias ok sets above the high threshold, clears below the low one.
// - External sync select set: main clock toggles on each sync pin rising edge.
// - Spread spectrum moves the reference by an 8-bit counter, rate and depth programmed.
// - Without modulation the reference stays at its nominal level.
// - Modulation steps once every modulation-divider count of main clock toggles.
// - Any write to the modulation register restarts the counter from nominal.
`timescale 1ns/1ps
module chan_ctrl #(
    parameter int OSC_PERIOD = chan_pkg::OSC_PERIOD_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_enable_pin,
    input wire logic i_sync_pin,
    input wire logic [chan_pkg::NUM_CH-1:0] i_dimming_signal,
    input wire logic [chan_pkg::NUM_CH-1:0] i_current_trip,
    input wire logic i_bias_above_on,
    input wire logic i_bias_below_off,
    input wire logic [chan_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [chan_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [chan_pkg::NUM_CH-1:0] o_main_switch,
    output logic o_main_clock,
    output logic o_supplies_on,
    output logic [chan_pkg::CNT_W-1:0] o_osc_ref
);
    import chan_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [4:0] ctrl;
        logic [15:0] level;
        logic [3:0] swdiv;
        logic [15:0] fm;
        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic bias_ok;
        logic [9:0] osc_cnt;
        logic [3:0] div_cnt;
        logic main_clk;
        logic sync_d;
        logic [NUM_CH-1:0] sw;
        logic supplies;
    } state_t;

    localparam state_t ST_RST = '{
        ctrl: CTRL_RST,
        level: LEVEL_RST,
        swdiv: SWDIV_RST,
        fm: FM_RST,
        default: '0
    };

    state_t s_r;
    state_t s_nxt;

    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    logic rstn_s;
    logic [7:0] pins_s;
    logic en_s;
    logic sync_s;
    logic bias_hi_s;
    logic bias_lo_s;
    logic [NUM_CH-1:0] dim_s;
    logic [NUM_CH-1:0] trip_s;

    pin_sync #(.W(1)) u_rst_sync (
        .i_clk(i_clk),
        .i_rstn(i_resetn),
        .i_ce(i_ce),
        .i_d(1'b1),
        .o_q(rstn_s)
    );

    // Every pin but reset crosses in as one group so the sampled levels line up
    pin_sync #(.W(8)) u_pin_sync (
        .i_clk(i_clk),
        .i_rstn(rstn_s),
        .i_ce(i_ce),
        .i_d({i_current_trip, i_dimming_signal, i_bias_below_off,
              i_bias_above_on, i_sync_pin, i_enable_pin}),
        .o_q(pins_s)
    );

    assign en_s = pins_s[0];
    assign sync_s = pins_s[1];
    assign bias_hi_s = pins_s[2];
    assign bias_lo_s = pins_s[3];
    assign dim_s = pins_s[5:4];
    assign trip_s = pins_s[7:6];

    // ****************************************
    // Channel run gating
    // ****************************************
    logic [NUM_CH-1:0] run_w;

    for (genvar g = 0; g < NUM_CH; g++) begin : g_run
        assign run_w[g] = en_s && s_r.bias_ok
            && s_r.ctrl[CTRL_EN_LSB + g] && dim_s[g]
            && (s_r.level[g*LEVEL_W +: LEVEL_W] > LEVEL_OFF_MAX);
    end

    // ****************************************
    // Spread spectrum counter
    // ****************************************
    logic fm_wr;
    logic main_tick;
    logic [CNT_W-1:0] ref_w;

    spread_mod u_spread (
        .i_clk(i_clk),
        .i_rstn(rstn_s),
        .i_ce(i_ce),
        .i_tick(main_tick),
        .i_restart(fm_wr || !en_s),
        .i_divider(s_r.fm[FM_DIV_LSB +: CNT_W]),
        .i_depth(s_r.fm[FM_DEPTH_LSB +: CNT_W]),
        .o_ref(ref_w)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic known(input logic [ADDR_W-1:0] a);
        return a[7:2] == CTRL_OFF[7:2] || a[7:2] == LEVEL_OFF[7:2]
            || a[7:2] == SWDIV_OFF[7:2] || a[7:2] == FM_OFF[7:2]
            || a[7:2] == STATUS_OFF[7:2];
    endfunction : known

    // ****************************************
    // Next state
    // ****************************************
    logic ch_tick;
    logic sync_rise;
    logic ext_sel;
    logic [31:0] wr_val;
    logic [31:0] rd_val;
    logic [3:0] div_f;

    always_comb begin
        s_nxt = s_r;
        fm_wr = 1'b0;
        main_tick = 1'b0;
        ch_tick = 1'b0;
        wr_val = '0;
        rd_val = '0;
        ext_sel = s_r.ctrl[CTRL_SYNC_BIT];
        sync_rise = sync_s && !s_r.sync_d;
        div_f = (s_r.swdiv == '0) ? 4'h1 : s_r.swdiv;

        // Write path: address and data may arrive in either order
        if (i_awvalid && s_r.awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.awaddr = i_awaddr;
        end
        if (i_wvalid && s_r.wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata = i_wdata;
            s_nxt.wstrb = i_wstrb;
        end
        if (i_bready && s_r.bvalid) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_nxt.aw_held && s_nxt.w_held) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = known(s_nxt.awaddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_nxt.awaddr[7:2])
                CTRL_OFF[7:2]: begin
                    wr_val = merge({27'h0, s_r.ctrl}, s_nxt.wdata, s_nxt.wstrb);
                    s_nxt.ctrl = wr_val[4:0];
                end
                LEVEL_OFF[7:2]: begin
                    wr_val = merge({16'h0, s_r.level}, s_nxt.wdata, s_nxt.wstrb);
                    s_nxt.level = wr_val[15:0];
                end
                SWDIV_OFF[7:2]: begin
                    wr_val = merge({28'h0, s_r.swdiv}, s_nxt.wdata, s_nxt.wstrb);
                    s_nxt.swdiv = wr_val[3:0];
                end
                FM_OFF[7:2]: begin
                    wr_val = merge({16'h0, s_r.fm}, s_nxt.wdata, s_nxt.wstrb);
                    s_nxt.fm = wr_val[15:0];
                    fm_wr = 1'b1;
                end
                default: begin
                    wr_val = '0;
                end
            endcase
        end
        // Readies fall while a response waits, so one write at a time
        s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;

        // Read path
        case (i_araddr[7:2])
            CTRL_OFF[7:2]: rd_val = {27'h0, s_r.ctrl};
            LEVEL_OFF[7:2]: rd_val = {16'h0, s_r.level};
            SWDIV_OFF[7:2]: rd_val = {28'h0, s_r.swdiv};
            FM_OFF[7:2]: rd_val = {16'h0, s_r.fm};
            STATUS_OFF[7:2]: begin
                rd_val[STAT_RUN_LSB +: NUM_CH] = s_r.sw;
                rd_val[STAT_BIAS_BIT] = s_r.bias_ok;
                rd_val[STAT_EN_BIT] = en_s;
                rd_val[STAT_SYNC_BIT] = ext_sel;
                rd_val[STAT_REF_LSB +: CNT_W] = ref_w;
            end
            default: rd_val = '0;
        endcase
        if (i_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_val;
            s_nxt.rresp = known(i_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (i_rready && s_r.rvalid) begin
            s_nxt.rvalid = 1'b0;
        end
        s_nxt.arready = !s_nxt.rvalid;

        // Bias comparator pair with fixed hysteresis
        if (bias_hi_s) begin
            s_nxt.bias_ok = 1'b1;
        end else if (bias_lo_s) begin
            s_nxt.bias_ok = 1'b0;
        end

        // Main clock: internal ramp stretched by the reference, or sync pin
        s_nxt.sync_d = sync_s;
        if (ext_sel) begin
            s_nxt.osc_cnt = '0;
            main_tick = sync_rise;
        end else if (s_r.osc_cnt >= 10'(OSC_PERIOD - 1) + {2'b00, ref_w}) begin
            s_nxt.osc_cnt = '0;
            main_tick = 1'b1;
        end else begin
            s_nxt.osc_cnt = s_r.osc_cnt + 10'h001;
        end
        if (main_tick) begin
            s_nxt.main_clk = !s_r.main_clk;
            if (s_r.div_cnt + 4'h1 >= div_f) begin
                s_nxt.div_cnt = '0;
                ch_tick = 1'b1;
            end else begin
                s_nxt.div_cnt = s_r.div_cnt + 4'h1;
            end
        end

        // Switching cycle; a new clock edge wins over a trip left from the last cycle
        for (int c = 0; c < NUM_CH; c++) begin
            s_nxt.sw[c] = run_w[c] && (ch_tick || (s_r.sw[c] && !trip_s[c]));
        end

        // Shutdown wipes configuration; bus keeps answering
        s_nxt.supplies = en_s;
        if (!en_s) begin
            s_nxt.ctrl = CTRL_RST;
            s_nxt.level = LEVEL_RST;
            s_nxt.swdiv = SWDIV_RST;
            s_nxt.fm = FM_RST;
        end
    end

    always_ff @(posedge i_clk or negedge rstn_s) begin
        if (!rstn_s) begin
            s_r <= ST_RST;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_awready = s_r.awready;
    assign o_wready = s_r.wready;
    assign o_bresp = s_r.bresp;
    assign o_bvalid = s_r.bvalid;
    assign o_arready = s_r.arready;
    assign o_rdata = s_r.rdata;
    assign o_rresp = s_r.rresp;
    assign o_rvalid = s_r.rvalid;
    assign o_main_switch = s_r.sw;
    assign o_main_clock = s_r.main_clk;
    assign o_supplies_on = s_r.supplies;
    assign o_osc_ref = ref_w;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rstn_s);

    a_shutdown_clears: assert property (
        (i_ce && !en_s) |=> (s_r.ctrl == CTRL_RST && s_r.fm == FM_RST
            && s_r.swdiv == SWDIV_RST && !o_supplies_on))
        else $error("config kept through shutdown");
    a_off_gated: assert property (
        (i_ce && (!en_s || !dim_s[0] || s_r.level[7:0] <= LEVEL_OFF_MAX)) |=> !o_main_switch[0])
        else $error("channel switched while gated off");
    a_cycle_start: assert property (
        (i_ce && run_w[1] && ch_tick) |=> o_main_switch[1])
        else $error("cycle did not start on channel clock");
    a_trip_end: assert property (
        (i_ce && o_main_switch[0] && trip_s[0] && !ch_tick) |=> !o_main_switch[0])
        else $error("trip did not end the cycle");
    a_bias_hyst: assert property (
        (i_ce && !bias_hi_s && !bias_lo_s) |=> $stable(s_r.bias_ok))
        else $error("bias state moved inside hysteresis");
    a_ext_clock: assert property (
        (i_ce && ext_sel && !sync_rise) |=> $stable(o_main_clock))
        else $error("main clock moved without sync edge");
    a_flat_ref: assert property (
        (i_ce && s_r.fm[15:8] == '0) |=> o_osc_ref == '0)
        else $error("reference moved without modulation");
    a_fm_restart: assert property (
        (i_ce && fm_wr) |=> o_osc_ref == '0)
        else $error("modulation counter not restarted");
    a_tri_step: assert property (
        (i_ce && en_s && !fm_wr) |=>
            (8'(o_osc_ref - $past(o_osc_ref)) inside {8'h00, 8'h01, 8'hFF}))
        else $error("reference jumped more than one step");

    c_switch_on: cover property ($rose(o_main_switch[0]));
    c_trip_off: cover property (o_main_switch[1] ##1 !o_main_switch[1]);
    c_ext_tick: cover property (ext_sel && sync_rise);
    c_fm_peak: cover property (o_osc_ref != '0 && o_osc_ref == s_r.fm[15:8]);
endmodule : chan_ctrl

// ---- rtl/chan_pkg.sv ----
// Shared constants for the channel enable and spread clock block
package chan_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_CH = 2;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 8;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] LEVEL_OFF = 8'h04;
    localparam logic [7:0] SWDIV_OFF = 8'h08;
    localparam logic [7:0] FM_OFF = 8'h0C;
    localparam logic [7:0] STATUS_OFF = 8'h10;
    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_SYNC_BIT = 4;
    localparam int LEVEL_W = 8;
    localparam int FM_DIV_LSB = 0;
    localparam int FM_DEPTH_LSB = 8;
    localparam int STAT_RUN_LSB = 0;
    localparam int STAT_BIAS_BIT = 2;
    localparam int STAT_EN_BIT = 3;
    localparam int STAT_SYNC_BIT = 4;
    localparam int STAT_REF_LSB = 8;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [15:0] LEVEL_RST = 16'h0000;
    localparam logic [3:0] SWDIV_RST = 4'h4;
    localparam logic [15:0] FM_RST = 16'h0000;
    localparam logic [7:0] LEVEL_OFF_MAX = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int MAIN_CLK_HZ = 1_000_000;
    localparam int OSC_PERIOD_CYC = CLK_HZ / MAIN_CLK_HZ;
endpackage : chan_pkg

// ---- rtl/pin_sync.sv ----
// Two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t s_r;
    sync_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = i_d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '0;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign o_q = s_r.s2;
endmodule : pin_sync

// ---- rtl/spread_mod.sv ----
// Triangular spread-spectrum counter for the oscillator reference
`timescale 1ns/1ps
module spread_mod (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_tick,
    input wire logic i_restart,
    input wire logic [chan_pkg::CNT_W-1:0] i_divider,
    input wire logic [chan_pkg::CNT_W-1:0] i_depth,
    output logic [chan_pkg::CNT_W-1:0] o_ref
);
    import chan_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] pre;
        logic [CNT_W-1:0] cnt;
        logic down;
    } spread_t;

    spread_t s_r;
    spread_t s_nxt;
    logic step;

    always_comb begin
        s_nxt = s_r;
        step = i_tick && (s_r.pre + 8'h01 >= i_divider);
        if (i_tick) begin
            s_nxt.pre = step ? '0 : s_r.pre + 8'h01;
        end
        if (step) begin
            if (!s_r.down) begin
                if (s_r.cnt >= i_depth) begin
                    s_nxt.down = 1'b1;
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end else begin
                    s_nxt.cnt = s_r.cnt + 8'h01;
                end
            end else if (s_r.cnt == '0) begin
                s_nxt.down = 1'b0;
                s_nxt.cnt = 8'h01;
            end else begin
                s_nxt.cnt = s_r.cnt - 8'h01;
            end
        end
        // Zero depth pins the reference flat
        if (i_restart || i_depth == '0) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '0;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign o_ref = s_r.cnt;

    a_rate_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !i_restart && !step && i_depth != '0) |=> $stable(s_r.cnt))
        else $error("reference moved between divider periods");
endmodule : spread_mod

// ---- sim/channel_enable_and_spread_clock_bench.sv ----
// Self-checking bench for the channel enable and spread clock block
`timescale 1ns/1ps
module channel_enable_and_spread_clock_bench;
    import chan_pkg::*;
    localparam int OSC = 6;
    logic i_clk, i_resetn, en_req, sync_run, en_pin, sync_pin, above_on, below_off;
    logic [1:0] dim, trip, bresp, rresp, sw, rsp, seen;
    logic [7:0] awaddr, araddr, osc_ref, v;
    logic [31:0] wdata, rd, rdata_w;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready, main_clk, sup_on;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] exp_ref [7] = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h01, 8'h00, 8'h01};
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int gap;
    chan_ctrl #(.OSC_PERIOD(OSC)) dut_u (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1), .i_enable_pin(en_pin),
        .i_sync_pin(sync_pin), .i_dimming_signal(dim), .i_current_trip(trip),
        .i_bias_above_on(above_on), .i_bias_below_off(below_off),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata_w), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .o_main_switch(sw), .o_main_clock(main_clk),
        .o_supplies_on(sup_on), .o_osc_ref(osc_ref)
    );
    sys_ctrl_model #(.HALF(5)) far_u (
        .i_clk(i_clk), .i_en_req(en_req), .i_sync_run(sync_run),
        .o_enable_pin(en_pin), .o_sync_pin(sync_pin)
    );
    // ****************************************
    // Clock and timeout
    // ****************************************
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic results();
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic ticks(input int n);
        repeat (n) @(posedge i_clk);
    endtask : ticks
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, got;
        aw = 1'b1;
        w = 1'b1;
        got = 1'b0;
        @(posedge i_clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(posedge i_clk);
            if (aw && awready === 1'b1) begin aw = 1'b0; awvalid <= 1'b0; end
            if (w && wready === 1'b1) begin w = 1'b0; wvalid <= 1'b0; end
            if (bready && bvalid === 1'b1) begin rsp = bresp; bready <= 1'b0; got = 1'b1; end
        end
    endtask : write
    task automatic read(input logic [7:0] a);
        logic got;
        got = 1'b0;
        @(posedge i_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!got) begin
            @(posedge i_clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rready && rvalid === 1'b1) begin
                rd = rdata_w;
                rsp = rresp;
                rready <= 1'b0;
                got = 1'b1;
            end
        end
    endtask : read
    // Settle pin synchronisers first, then record every switch seen on
    task automatic watch(input int n);
        ticks(5);
        seen = 2'b00;
        repeat (n) begin @(posedge i_clk); seen = seen | sw; end
    endtask : watch
    task automatic wait_sw0();
        for (int k = 0; k < 80 && sw[0] !== 1'b1; k++) @(posedge i_clk);
    endtask : wait_sw0
    task automatic gap_main(output int g);
        logic p;
        p = main_clk;
        for (int k = 0; k < 500 && main_clk === p; k++) @(posedge i_clk);
        p = main_clk;
        g = 0;
        do begin @(posedge i_clk); g++; end while (main_clk === p && g < 500);
    endtask : gap_main
    // Main clock toggles counted until the spread counter moves
    task automatic next_ref(output int t);
        logic [7:0] last;
        logic p;
        last = osc_ref;
        p = main_clk;
        t = 0;
        for (int k = 0; k < 2000 && osc_ref === last; k++) begin
            @(posedge i_clk);
            if (main_clk !== p) begin t++; p = main_clk; end
        end
        v = osc_ref;
    endtask : next_ref
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        i_resetn = 0; en_req = 0; sync_run = 0; above_on = 0; below_off = 0; dim = 0; trip = 0;
        awaddr = 0; awvalid = 0; wdata = 0; wstrb = 0; wvalid = 0; bready = 0;
        araddr = 0; arvalid = 0; rready = 0;
        ticks(5);
        i_resetn <= 1'b1;
        ticks(4);
        en_req <= 1'b1;
        ticks(6);
        read(CTRL_OFF); check(rd, 32'h0);
        read(LEVEL_OFF); check(rd, 32'h0);
        read(SWDIV_OFF); check(rd, 32'h4);
        read(FM_OFF); check(rd, 32'h0);
        read(8'h14); check(rsp, RESP_SLVERR);
        check(sup_on, 1'b1);
        $display("Test reset values done");
        above_on <= 1'b1; ticks(4); above_on <= 1'b0; dim <= 2'b11;
        write(CTRL_OFF, 32'h3); write(LEVEL_OFF, 32'h0908);
        watch(60); check(seen, 2'b10);
        dim <= 2'b01; write(LEVEL_OFF, 32'h0909);
        watch(60); check(seen, 2'b01);
        dim <= 2'b11; write(CTRL_OFF, 32'h2);
        watch(60); check(seen, 2'b10);
        $display("Test run gating done");
        write(CTRL_OFF, 32'h3); trip <= 2'b01; ticks(30);
        wait_sw0(); check(sw[0], 1'b1);
        ticks(3); check(sw[0], 1'b0);
        trip <= 2'b00; wait_sw0(); check(sw[0], 1'b1);
        ticks(30); check(sw[0], 1'b1);
        $display("Test switching cycle done");
        below_off <= 1'b1; ticks(4);
        read(STATUS_OFF); check(rd[2], 1'b0);
        watch(60); check(seen, 2'b00);
        below_off <= 1'b0; ticks(4);
        read(STATUS_OFF); check(rd[2], 1'b0);
        above_on <= 1'b1; ticks(4); above_on <= 1'b0;
        read(STATUS_OFF); check(rd[2], 1'b1);
        $display("Test bias hysteresis done");
        gap_main(gap); check(32'(gap), 32'(OSC));
        check(osc_ref, 8'h00);
        write(FM_OFF, 32'h0302);
        for (int i = 0; i < 7; i++) begin
            next_ref(gap);
            check(v, exp_ref[i]);
            if (i > 0) check(32'(gap), 32'h2);
        end
        write(FM_OFF, 32'h0302); check(osc_ref, 8'h00);
        check(rsp, RESP_OKAY);
        $display("Test spread spectrum done");
        write(CTRL_OFF, 32'h13); sync_run <= 1'b1; ticks(30);
        gap_main(gap); check(32'(gap), 32'hA);
        read(STATUS_OFF); check(rd[4], 1'b1);
        sync_run <= 1'b0;
        write(SWDIV_OFF, 32'h2); read(SWDIV_OFF); check(rd, 32'h2);
        $display("Test external sync done");
        en_req <= 1'b0; ticks(6);
        check(sup_on, 1'b0);
        check(sw, 2'b00);
        read(CTRL_OFF); check(rd, 32'h0);
        read(FM_OFF); check(rd, 32'h0);
        read(SWDIV_OFF); check(rd, 32'h4);
        check(osc_ref, 8'h00);
        $display("Test shutdown done");
        results();
    end
endmodule : channel_enable_and_spread_clock_bench

// ---- sim/sys_ctrl_model.sv ----
// Model of the system controller driving the enable and sync pins
`timescale 1ns/1ps
module sys_ctrl_model #(
    parameter int HALF = 5
) (
    input wire logic i_clk,
    input wire logic i_en_req,
    input wire logic i_sync_run,
    output logic o_enable_pin,
    output logic o_sync_pin
);
    int cnt = 0;
    initial begin
        o_enable_pin = 1'b0;
        o_sync_pin = 1'b0;
    end
    // ****************************************
    // Pin drive
    // ****************************************
    always @(posedge i_clk) begin
        o_enable_pin <= i_en_req;
        // Square wave only while asked for; the pin rests low otherwise
        if (!i_sync_run) begin
            cnt <= 0;
            o_sync_pin <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            o_sync_pin <= !o_sync_pin;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : sys_ctrl_model
